/* File: rtl/dtc_pkg.sv */
// Constants and types shared by the dual timer/counter control block.
package dtc_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] DTC_PRESCALE_ADDR = 8'h86;
   localparam logic [7:0] DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR     = 8'h88;
   localparam logic [7:0] DTC_TIMER_MODE_SELECT_ADDR     = 8'h89;
   localparam logic [7:0] DTC_TL0_ADDR      = 8'h8A;
   localparam logic [7:0] DTC_TL1_ADDR      = 8'h8B;
   localparam logic [7:0] DTC_TH0_ADDR      = 8'h8C;
   localparam logic [7:0] DTC_TH1_ADDR      = 8'h8D;
   localparam logic [7:0] DTC_CLKCFG_ADDR   = 8'h8E;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int         DTC_DIVSEL_ONE_BIT  = 4;
   localparam int         DTC_DIVSEL_ZERO_BIT = 3;
   localparam logic [7:0] DTC_REG_RESET       = 8'h00;
   localparam logic [7:0] DTC_READ_UNMAPPED   = 8'h00;

   // Vector acknowledge bit positions.
   localparam int DTC_ACK_EXT0 = 0;
   localparam int DTC_ACK_TMR0 = 1;
   localparam int DTC_ACK_EXT1 = 2;
   localparam int DTC_ACK_TMR1 = 3;

   // ------------------------------------------------------------
   // Clock division counts
   // ------------------------------------------------------------
   localparam logic [3:0] DTC_DIV12_LAST = 4'hB;
   localparam logic [6:0] DTC_MASK_DIV4   = 7'h03;
   localparam logic [6:0] DTC_MASK_DIV16  = 7'h0F;
   localparam logic [6:0] DTC_MASK_DIV32  = 7'h1F;
   localparam logic [6:0] DTC_MASK_DIV128 = 7'h7F;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DTC_MODE_13     = 2'b00,
      DTC_MODE_16     = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT  = 2'b11
   } dtc_mode_e;

   typedef struct packed {
      logic overflow_flag_one;
      logic run_bit_one;
      logic overflow_flag_zero;
      logic run_bit_zero;
      logic ext_irq_flag_one;
      logic ext_irq_type_one;
      logic ext_irq_flag_zero;
      logic ext_irq_type_zero;
   } dtc_timer_run_and_flag_control_s;

   typedef struct packed {
      logic      pin_qualify;
      logic      count_external;
      dtc_mode_e mode;
   } dtc_timer_mode_select_half_s;

   typedef struct packed {
      dtc_timer_mode_select_half_s one;
      dtc_timer_mode_select_half_s zero;
   } dtc_timer_mode_select_s;

endpackage

/* File: rtl/dtc_top.sv */
// Dual 16-bit timer/counter with run, gate, source and flag control.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module dtc_top
   import dtc_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_en_in,
   input  wire logic       rd_en_in,
   input  wire logic       ext_irq_input_zero_in,
   input  wire logic       ext_irq_input_one_in,
   input  wire logic       count_pin_zero_in,
   input  wire logic       count_pin_one_in,
   input  wire logic [3:0] vec_ack_in,
   output logic      [7:0] rd_data_out,
   output logic      [3:0] irq_req_out
);

   // ------------------------------------------------------------
   // Counting step
   // ------------------------------------------------------------
   // Returns {overflow, high, low} after one count in the given mode.
   function automatic logic [16:0] dtc_step(input dtc_mode_e m,
                                            input logic [7:0] th,
                                            input logic [7:0] tl);
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      s13 = {1'b0, th, tl[4:0]} + 14'h0001;
      s16 = {1'b0, th, tl} + 17'h0_0001;
      s8  = {1'b0, tl} + 9'h001;
      case (m)
         DTC_MODE_13:     dtc_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
         DTC_MODE_16:     dtc_step = s16;
         DTC_MODE_RELOAD: dtc_step = {s8[8], th, (s8[8] ? th : s8[7:0])};
         default:         dtc_step = {s8[8], th, s8[7:0]};
      endcase
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   dtc_timer_run_and_flag_control_s  timer_run_and_flag_control;
   dtc_timer_mode_select_s  timer_mode_select;
   logic [7:0] tl0, th0, tl1, th1;
   logic [1:0] prescale;
   logic       divsel0, divsel1;
   logic [6:0] free_cnt;
   logic [3:0] div12_cnt;
   logic       cp0_prev, cp1_prev, ext_irq_input_zero_prev, ext_irq_input_one_prev;

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   wire wr_timer_run_and_flag_control = wr_en_in && (addr_in == DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR);
   wire wr_timer_mode_select = wr_en_in && (addr_in == DTC_TIMER_MODE_SELECT_ADDR);
   wire wr_tl0  = wr_en_in && (addr_in == DTC_TL0_ADDR);
   wire wr_tl1  = wr_en_in && (addr_in == DTC_TL1_ADDR);
   wire wr_th0  = wr_en_in && (addr_in == DTC_TH0_ADDR);
   wire wr_th1  = wr_en_in && (addr_in == DTC_TH1_ADDR);
   wire wr_ckc  = wr_en_in && (addr_in == DTC_CLKCFG_ADDR);
   wire wr_psc  = wr_en_in && (addr_in == DTC_PRESCALE_ADDR);
   wire dtc_timer_run_and_flag_control_s wr_timer_run_and_flag_control_val = dtc_timer_run_and_flag_control_s'(wr_data_in);

   // Unmapped offsets and unused bits read as zero.
   wire [7:0] ckc_rd = {3'h0, divsel1, divsel0, 3'h0};
   wire [7:0] rd_mux =
      (addr_in == DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR)     ? timer_run_and_flag_control :
      (addr_in == DTC_TIMER_MODE_SELECT_ADDR)     ? timer_mode_select :
      (addr_in == DTC_TL0_ADDR)      ? tl0  :
      (addr_in == DTC_TL1_ADDR)      ? tl1  :
      (addr_in == DTC_TH0_ADDR)      ? th0  :
      (addr_in == DTC_TH1_ADDR)      ? th1  :
      (addr_in == DTC_CLKCFG_ADDR)   ? ckc_rd :
      (addr_in == DTC_PRESCALE_ADDR) ? {6'h00, prescale} : DTC_READ_UNMAPPED;

   // ------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------
   // One free counter serves every power-of-two divide so both timers stay in phase.
   wire [6:0] psc_mask = (prescale == 2'b00) ? DTC_MASK_DIV4  :
                         (prescale == 2'b01) ? DTC_MASK_DIV16 :
                         (prescale == 2'b10) ? DTC_MASK_DIV32 : DTC_MASK_DIV128;
   wire tick4    = ((free_cnt & DTC_MASK_DIV4) == DTC_MASK_DIV4);
   wire tick_psc = ((free_cnt & psc_mask) == psc_mask);
   wire tick12   = (div12_cnt == DTC_DIV12_LAST);
   wire t0_int   = divsel0 ? tick_psc : tick12;
   wire t1_int   = divsel1 ? tick4 : tick12;

   // ------------------------------------------------------------
   // Count enables
   // ------------------------------------------------------------
   wire fall_cp0  = cp0_prev & ~count_pin_zero_in;
   wire fall_cp1  = cp1_prev & ~count_pin_one_in;
   wire fall_ext_irq_input_zero = ext_irq_input_zero_prev & ~ext_irq_input_zero_in;
   wire fall_ext_irq_input_one = ext_irq_input_one_prev & ~ext_irq_input_one_in;
   wire en0  = timer_run_and_flag_control.run_bit_zero & (~timer_mode_select.zero.pin_qualify | ext_irq_input_zero_in);
   wire en1  = timer_run_and_flag_control.run_bit_one & (~timer_mode_select.one.pin_qualify | ext_irq_input_one_in);
   wire src0 = timer_mode_select.zero.count_external ? fall_cp0 : t0_int;
   wire src1 = timer_mode_select.one.count_external ? fall_cp1 : t1_int;
   wire split0 = (timer_mode_select.zero.mode == DTC_MODE_SPLIT);
   wire inc0   = en0 & src0;
   // Timer one halts in split mode of its own field.
   wire inc1   = en1 & src1 & (timer_mode_select.one.mode != DTC_MODE_SPLIT);
   // In split mode the high byte of timer zero is a plain timer on timer one's run bit.
   wire inc0h  = split0 & timer_run_and_flag_control.run_bit_one & t1_int;

   wire [16:0] step0 = dtc_step(timer_mode_select.zero.mode, th0, tl0);
   wire [16:0] step1 = dtc_step(timer_mode_select.one.mode, th1, tl1);
   wire [8:0]  th0_inc = {1'b0, th0} + 9'h001;
   wire ovf0 = inc0 & step0[16];
   // Split mode steals timer one's flag, so timer one overflows are dropped then.
   wire ovf1 = (inc1 & step1[16] & ~split0) | (inc0h & th0_inc[8]);

   // ------------------------------------------------------------
   // Next values of counters
   // ------------------------------------------------------------
   // A software write beats a count in the same cycle.
   wire [7:0] next_tl0 = wr_tl0 ? wr_data_in : (inc0 ? step0[7:0] : tl0);
   wire [7:0] next_th0 = wr_th0 ? wr_data_in :
                         (inc0 & ~split0) ? step0[15:8] :
                         inc0h ? th0_inc[7:0] : th0;
   wire [7:0] next_tl1 = wr_tl1 ? wr_data_in : (inc1 ? step1[7:0] : tl1);
   wire [7:0] next_th1 = wr_th1 ? wr_data_in : (inc1 ? step1[15:8] : th1);

   // ------------------------------------------------------------
   // Next value of control register
   // ------------------------------------------------------------
   // Hardware setting wins over both software clear and vector clear.
   dtc_timer_run_and_flag_control_s next_timer_run_and_flag_control;
   always_comb begin
      next_timer_run_and_flag_control = wr_timer_run_and_flag_control ? wr_timer_run_and_flag_control_val : timer_run_and_flag_control;
      next_timer_run_and_flag_control.overflow_flag_one = ovf1 |
         (wr_timer_run_and_flag_control ? wr_timer_run_and_flag_control_val.overflow_flag_one
                  : timer_run_and_flag_control.overflow_flag_one & ~vec_ack_in[DTC_ACK_TMR1]);
      next_timer_run_and_flag_control.overflow_flag_zero = ovf0 |
         (wr_timer_run_and_flag_control ? wr_timer_run_and_flag_control_val.overflow_flag_zero
                  : timer_run_and_flag_control.overflow_flag_zero & ~vec_ack_in[DTC_ACK_TMR0]);
      // Level mode simply mirrors the inverted input; acks have no effect there.
      next_timer_run_and_flag_control.ext_irq_flag_one = timer_run_and_flag_control.ext_irq_type_one ?
         (fall_ext_irq_input_one | (wr_timer_run_and_flag_control ? wr_timer_run_and_flag_control_val.ext_irq_flag_one
                   : timer_run_and_flag_control.ext_irq_flag_one & ~vec_ack_in[DTC_ACK_EXT1]))
         : ~ext_irq_input_one_in;
      next_timer_run_and_flag_control.ext_irq_flag_zero = timer_run_and_flag_control.ext_irq_type_zero ?
         (fall_ext_irq_input_zero | (wr_timer_run_and_flag_control ? wr_timer_run_and_flag_control_val.ext_irq_flag_zero
                   : timer_run_and_flag_control.ext_irq_flag_zero & ~vec_ack_in[DTC_ACK_EXT0]))
         : ~ext_irq_input_zero_in;
   end

   // ------------------------------------------------------------
   // Control and mode registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         timer_run_and_flag_control <= dtc_timer_run_and_flag_control_s'(DTC_REG_RESET);
         timer_mode_select <= dtc_timer_mode_select_s'(DTC_REG_RESET);
      end else begin
         timer_run_and_flag_control <= next_timer_run_and_flag_control;
         if (wr_timer_mode_select) begin
            timer_mode_select <= dtc_timer_mode_select_s'(wr_data_in);
         end
      end
   end

   // ------------------------------------------------------------
   // Counters and clock configuration
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         tl0      <= DTC_REG_RESET;
         th0      <= DTC_REG_RESET;
         tl1      <= DTC_REG_RESET;
         th1      <= DTC_REG_RESET;
         prescale <= 2'b00;
         divsel0  <= 1'b0;
         divsel1  <= 1'b0;
      end else begin
         tl0 <= next_tl0;
         th0 <= next_th0;
         tl1 <= next_tl1;
         th1 <= next_th1;
         if (wr_psc) begin
            prescale <= wr_data_in[1:0];
         end
         if (wr_ckc) begin
            divsel0 <= wr_data_in[DTC_DIVSEL_ZERO_BIT];
            divsel1 <= wr_data_in[DTC_DIVSEL_ONE_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Time base and pin history
   // ------------------------------------------------------------
   // Pins idle high, so history resets high to avoid a false edge.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         free_cnt  <= 7'h00;
         div12_cnt <= 4'h0;
         cp0_prev  <= 1'b1;
         cp1_prev  <= 1'b1;
         ext_irq_input_zero_prev <= 1'b1;
         ext_irq_input_one_prev <= 1'b1;
      end else begin
         free_cnt  <= free_cnt + 7'h01;
         div12_cnt <= tick12 ? 4'h0 : div12_cnt + 4'h1;
         cp0_prev  <= count_pin_zero_in;
         cp1_prev  <= count_pin_one_in;
         ext_irq_input_zero_prev <= ext_irq_input_zero_in;
         ext_irq_input_one_prev <= ext_irq_input_one_in;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         rd_data_out <= 8'h00;
         irq_req_out <= 4'h0;
      end else begin
         rd_data_out <= rd_en_in ? rd_mux : 8'h00;
         irq_req_out <= {next_timer_run_and_flag_control.overflow_flag_one, next_timer_run_and_flag_control.ext_irq_flag_one,
                         next_timer_run_and_flag_control.overflow_flag_zero, next_timer_run_and_flag_control.ext_irq_flag_zero};
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking dtc_cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   div4_period_a: assert property (
      tick4 |=> !tick4 [*3] ##1 tick4)
      else $error("Divide by four strobe period wrong.");
   tf1_set_a: assert property (
      ovf1 |=> timer_run_and_flag_control.overflow_flag_one && irq_req_out[3])
      else $error("Timer one overflow did not set flag.");
   tf0_ack_a: assert property (
      (vec_ack_in[DTC_ACK_TMR0] && !ovf0 && !wr_timer_run_and_flag_control) |=> !timer_run_and_flag_control.overflow_flag_zero)
      else $error("Timer zero flag not cleared by acknowledge.");
   run0_stop_a: assert property (
      (!timer_run_and_flag_control.run_bit_zero && !wr_tl0) |=> $stable(tl0))
      else $error("Timer zero low byte moved while stopped.");
   lvl1_track_a: assert property (
      (!timer_run_and_flag_control.ext_irq_type_one && !wr_timer_run_and_flag_control)
      |=> timer_run_and_flag_control.ext_irq_flag_one == !$past(ext_irq_input_one_in))
      else $error("Level flag one does not track input.");
   edge0_latch_a: assert property (
      (timer_run_and_flag_control.ext_irq_type_zero && !wr_timer_run_and_flag_control && $fell(ext_irq_input_zero_in))
      |=> timer_run_and_flag_control.ext_irq_flag_zero)
      else $error("Falling edge on input zero not latched.");
   gate1_hold_a: assert property (
      (timer_mode_select.one.pin_qualify && !ext_irq_input_one_in && !wr_tl1 && !wr_th1)
      |=> $stable({th1, tl1}))
      else $error("Gated timer one counted with input low.");
   split_stop_a: assert property (
      (timer_mode_select.one.mode == DTC_MODE_SPLIT && !wr_tl1) |=> $stable(tl1))
      else $error("Timer one counted in its split mode.");
   reset_zero_a: assert property (disable iff (1'b0)
      !rst_b_in |=> (timer_run_and_flag_control == '0) && (timer_mode_select == '0))
      else $error("Control or mode register not zero after reset.");
   tf0_set_a: assert property (
      ovf0 |=> timer_run_and_flag_control.overflow_flag_zero && irq_req_out[1])
      else $error("Timer zero overflow did not set flag.");
   lvl0_track_a: assert property (
      !timer_run_and_flag_control.ext_irq_type_zero |=> timer_run_and_flag_control.ext_irq_flag_zero == !$past(ext_irq_input_zero_in))
      else $error("Level flag zero does not track input.");
   ext1_ack_a: assert property (
      (timer_run_and_flag_control.ext_irq_type_one && vec_ack_in[DTC_ACK_EXT1] && !fall_ext_irq_input_one && !wr_timer_run_and_flag_control)
      |=> !timer_run_and_flag_control.ext_irq_flag_one)
      else $error("Edge flag one not cleared by acknowledge.");
   pin_count0_a: assert property (
      (timer_mode_select.zero.count_external && !timer_mode_select.zero.pin_qualify && timer_run_and_flag_control.run_bit_zero
       && timer_mode_select.zero.mode == DTC_MODE_16 && fall_cp0 && !wr_tl0 && !wr_th0)
      |=> {th0, tl0} == $past({th0, tl0}) + 16'h0001)
      else $error("Falling count pin edge not counted by timer zero.");

   ovf0_cov_c: cover property (ovf0 ##1 vec_ack_in[DTC_ACK_TMR0]);
   split_cov_c: cover property (inc0h && th0_inc[8]);
   reload_cov_c: cover property (inc1 && step1[16] && timer_mode_select.one.mode == DTC_MODE_RELOAD);
   edge1_cov_c: cover property (timer_run_and_flag_control.ext_irq_type_one && fall_ext_irq_input_one);
   gate0_cov_c: cover property (
      timer_mode_select.zero.pin_qualify && timer_run_and_flag_control.run_bit_zero && !ext_irq_input_zero_in);

endmodule

/* File: verif/dtc_pin_model.sv */
// Pin-side partner model: external interrupt pins and external count pins.
`timescale 1ns/1ps
module dtc_pin_model (
   input  wire logic clk_sys_in,
   output logic      ext_irq_input_zero_out,
   output logic      ext_irq_input_one_out,
   output logic      count_pin_zero_out,
   output logic      count_pin_one_out
);
   // ------------------------------------------------------------
   // Pin levels
   // ------------------------------------------------------------
   // Both pin pairs idle high, so the gates stay open and nothing is requested.
   logic [1:0] ext_lvl = 2'b11;
   logic [1:0] cnt_lvl = 2'b11;

   // Bit 0 drives the zero pins and bit 1 the one pins.
   assign ext_irq_input_zero_out = ext_lvl[0];
   assign ext_irq_input_one_out  = ext_lvl[1];
   assign count_pin_zero_out     = cnt_lvl[0];
   assign count_pin_one_out      = cnt_lvl[1];

   // ------------------------------------------------------------
   // Driving tasks
   // ------------------------------------------------------------
   // Sets the interrupt pins and lets one edge pass so the block samples them.
   task automatic set_ext(input logic [1:0] lvl);
      @(posedge clk_sys_in);
      ext_lvl <= lvl;
      @(posedge clk_sys_in);
   endtask

   // Each pulse is low for one cycle and high for one, the shortest edge the block can see.
   task automatic fall(input logic [1:0] sel, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys_in);
         cnt_lvl <= ~sel;
         @(posedge clk_sys_in);
         cnt_lvl <= 2'b11;
      end
      @(posedge clk_sys_in);
   endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench for the dual timer/counter control block.
`timescale 1ns/1ps
module tb_top
   import dtc_pkg::*;
;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   localparam int DIV0 [5] = '{4, 16, 32, 128, 12};
   logic       clk_sys = 1'b0;
   logic       rst_b;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic       wr_en;
   logic       rd_en;
   logic [3:0] vec_ack;
   logic [7:0] rd_data;
   logic [3:0] irq_req;
   logic       ext0, ext1, cp0, cp1;
   int         error_cnt = 0;
   int         n_checks  = 0;

   // Free-running 100 MHz clock.
   always #5 clk_sys = ~clk_sys;

   dtc_pin_model pins (.clk_sys_in(clk_sys), .ext_irq_input_zero_out(ext0),
      .ext_irq_input_one_out(ext1), .count_pin_zero_out(cp0), .count_pin_one_out(cp1));

   dtc_top dut (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .addr_in(addr), .wr_data_in(wr_data),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .ext_irq_input_zero_in(ext0),
      .ext_irq_input_one_in(ext1), .count_pin_zero_in(cp0), .count_pin_one_in(cp1),
      .vec_ack_in(vec_ack), .rd_data_out(rd_data), .irq_req_out(irq_req));

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Case inequality so an unknown never passes as a match.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk_sys);
      wr_en   <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just after that edge.
   // One cycle later they must have fallen back to zero.
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, exp);
      @(posedge clk_sys);
      #1;
      chk(rd_data, 8'h00);
   endtask

   task automatic ack(input logic [3:0] m);
      @(posedge clk_sys);
      vec_ack <= m;
      @(posedge clk_sys);
      vec_ack <= 4'h0;
   endtask

   task automatic setc(input logic [7:0] t0, t1, h0, h1);
      wr(DTC_TL0_ADDR, t0);
      wr(DTC_TL1_ADDR, t1);
      wr(DTC_TH0_ADDR, h0);
      wr(DTC_TH1_ADDR, h1);
   endtask

   task automatic chkc(input logic [7:0] t0, t1, h0, h1);
      rdc(DTC_TL0_ADDR, t0);
      rdc(DTC_TL1_ADDR, t1);
      rdc(DTC_TH0_ADDR, h0);
      rdc(DTC_TH1_ADDR, h1);
   endtask

   // The run window is 384 edges, a multiple of every divide, so counts are phase-free.
   task automatic win(input logic [7:0] tc);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, tc);
      repeat (382) @(posedge clk_sys);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
   endtask

   // Cuts a hang short and reports it as a mismatch.
   initial begin
      repeat (100000) @(posedge clk_sys);
      error_cnt++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] v;
      int         t;
      void'($urandom(32'h9211));
      // Bus idle and reset held from time zero, before the first edge.
      rst_b   <= 1'b0;
      addr    <= 8'h00;
      wr_data <= 8'h00;
      wr_en   <= 1'b0;
      rd_en   <= 1'b0;
      vec_ack <= 4'h0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
      rdc(DTC_TIMER_MODE_SELECT_ADDR, 8'h00);
      wr(8'h80, 8'hFF);
      rdc(8'h80, 8'h00);
      wr(DTC_CLKCFG_ADDR, 8'hFF);
      rdc(DTC_CLKCFG_ADDR, 8'h18);
      wr(DTC_PRESCALE_ADDR, 8'hFF);
      rdc(DTC_PRESCALE_ADDR, 8'h03);
      repeat (4) begin
         v = 8'($urandom);
         wr(DTC_TIMER_MODE_SELECT_ADDR, v);
         rdc(DTC_TIMER_MODE_SELECT_ADDR, v);
      end
      // Internal time base: every prescale code and both divide selects.
      for (int i = 0; i < 5; i++) begin
         wr(DTC_TIMER_MODE_SELECT_ADDR, 8'h11);
         setc(8'h00, 8'h00, 8'h00, 8'h00);
         wr(DTC_PRESCALE_ADDR, 8'(i % 4));
         wr(DTC_CLKCFG_ADDR, 8'((i % 2) * 16 + (i < 4) * 8));
         win(8'h50);
         chkc(8'(384 / DIV0[i]), 8'(384 / (i % 2 ? 4 : 12)), 8'h00, 8'h00);
      end
      wr(DTC_TIMER_MODE_SELECT_ADDR, 8'h33);
      wr(DTC_CLKCFG_ADDR, 8'h00);
      setc(8'h00, 8'h00, 8'h00, 8'h00);
      win(8'h50);
      chkc(8'h20, 8'h00, 8'h20, 8'h00);
      // External counting, gating and run control.
      setc(8'h00, 8'h00, 8'h00, 8'h00);
      wr(DTC_TIMER_MODE_SELECT_ADDR, 8'hDD);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h50);
      pins.fall(2'b11, 3);
      chkc(8'h03, 8'h03, 8'h00, 8'h00);
      pins.set_ext(2'b00);
      pins.fall(2'b11, 2);
      chkc(8'h03, 8'h03, 8'h00, 8'h00);
      wr(DTC_TIMER_MODE_SELECT_ADDR, 8'h55);
      pins.fall(2'b11, 2);
      chkc(8'h05, 8'h05, 8'h00, 8'h00);
      pins.set_ext(2'b11);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h10);
      pins.fall(2'b11, 1);
      chkc(8'h06, 8'h05, 8'h00, 8'h00);
      t = $urandom_range(1, 7);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h40);
      pins.fall(2'b11, t);
      chkc(8'h06, 8'(5 + t), 8'h00, 8'h00);
      // Overflow in 16-bit, reload and 13-bit modes.
      t = $urandom_range(200, 255);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
      setc(8'(t), 8'(t), 8'hFF, 8'hFF);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h50);
      pins.fall(2'b11, 256 - t);
      chkc(8'h00, 8'h00, 8'h00, 8'h00);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'hF0);
      chk({4'h0, irq_req}, 8'h0A);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
      wr(DTC_TIMER_MODE_SELECT_ADDR, 8'h66);
      t = $urandom_range(0, 253);
      setc(8'hFE, 8'hFE, 8'(t), 8'(t));
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h50);
      pins.fall(2'b11, 3);
      chkc(8'(t + 1), 8'(t + 1), 8'(t), 8'(t));
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'hF0);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
      wr(DTC_TIMER_MODE_SELECT_ADDR, 8'h44);
      setc(8'hFF, 8'hFF, 8'hFF, 8'hFF);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h50);
      pins.fall(2'b11, 1);
      chkc(8'hE0, 8'hE0, 8'h00, 8'h00);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'hF0);
      // Software and acknowledge control of the flags.
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'hA0);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'hA0);
      chk({4'h0, irq_req}, 8'h0A);
      ack(4'b0010);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h80);
      ack(4'b1000);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
      pins.set_ext(2'b00);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h0A);
      ack(4'b0101);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h0A);
      pins.set_ext(2'b11);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h00);
      wr(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h05);
      pins.set_ext(2'b00);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h0F);
      chk({4'h0, irq_req}, 8'h05);
      ack(4'b0001);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h0D);
      ack(4'b0100);
      rdc(DTC_TIMER_RUN_AND_FLAG_CONTROL_ADDR, 8'h05);
      pins.set_ext(2'b11);
      complete_run();
   end
endmodule
